// ### bench/cpu_system_control_decode_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_system_control_decode_tb_top;
    import scd_pkg::*;
    logic mclk, resetn, trap_ack, wake, slow, trap_req, sleeping;
    logic [1:0] trap_vec;
    logic [7:0] flags, brd, bwr;
    logic [23:0] vec_addr, pc;
    scd_mem_req_type mem_out;
    scd_mem_rsp_type mem_in;
    int mismatches, cmp_count, cycles;

    scd_core u_dut (.MCLK(mclk), .RESETN(resetn), .MEM_OUT(mem_out), .MEM_IN(mem_in), .TRAP_REQ(trap_req),
        .TRAP_VEC(trap_vec), .TRAP_ACK(trap_ack), .VEC_ADDR(vec_addr), .WAKE(wake), .SLEEPING(sleeping),
        .FLAGS(flags), .PC(pc));
    scd_mem_model u_mem (.clk(mclk), .rst_n(resetn), .slow(slow), .req_in(mem_out), .rsp_out(mem_in),
        .byte_rd_cnt(brd), .byte_wr_cnt(bwr));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Six short programs need well under 5000 cycles; the ceiling leaves ample slack
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            end_of_test();
        end
    end

    task end_of_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task prog(input logic [15:0] w[$]);
        foreach (w[i]) u_mem.mem[i] = w[i];
    endtask : prog

    task start(input logic s);
        resetn <= 1'b0;
        slow <= s;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
    endtask : start

    task wait_sleep();
        int n;
        n = 0;
        repeat (2) @(posedge mclk);
        while (sleeping !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        #1;
        chk("sleeping", 32'h1, {31'h0, sleeping});
    endtask : wait_sleep

    task test_flags();
        prog({16'h11a5, 16'h100f, 16'h12ff, 16'h0000, 16'h0001, 16'h0000, 16'h0001});
        start(1'b0);
        wait_sleep();
        chk("flags", 32'hfa, {24'h0, flags});
        chk("pc", 32'h0a, {8'h0, pc});
        @(posedge mclk);
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        wait_sleep();
        chk("pc after wake", 32'h0e, {8'h0, pc});
        chk("flags after nop", 32'hfa, {24'h0, flags});
        $display("test flags done");
    endtask : test_flags

    task test_store_load();
        prog({16'h7012, 16'h0000, 16'h0100, 16'h11c3, 16'h3810, 16'h7022, 16'h0000, 16'h0102,
            16'h1000, 16'h2820, 16'h0001});
        u_mem.mem[9'h081] = 16'h5a3c;
        start(1'b1);
        wait_sleep();
        chk("stored word", 32'hc300, {16'h0, u_mem.mem[9'h080]});
        chk("byte writes", 32'h0, {24'h0, bwr});
        chk("flags loaded", 32'h5a, {24'h0, flags});
        chk("byte reads", 32'h0, {24'h0, brd});
        chk("pc", 32'h16, {8'h0, pc});
        $display("test store load done");
    endtask : test_store_load

    task test_move();
        prog({16'h7053, 16'h0000, 16'h0200, 16'h7062, 16'h0000, 16'h0300, 16'h7041, 16'h0103, 16'h4000,
            16'h7062, 16'h0000, 16'h0310, 16'h7041, 16'h0000, 16'h4001, 16'h0001});
        u_mem.mem[9'h100] = 16'h1122;
        u_mem.mem[9'h101] = 16'h3344;
        u_mem.mem[9'h180] = 16'hffff;
        u_mem.mem[9'h181] = 16'hffff;
        u_mem.mem[9'h188] = 16'hffff;
        start(1'b0);
        wait_sleep();
        chk("dest word 0", 32'h1122, {16'h0, u_mem.mem[9'h180]});
        chk("dest word 1", 32'h33ff, {16'h0, u_mem.mem[9'h181]});
        chk("zero count dest", 32'hffff, {16'h0, u_mem.mem[9'h188]});
        chk("bytes moved", 32'h3, {24'h0, bwr});
        chk("pc", 32'h20, {8'h0, pc});
        $display("test move done");
    endtask : test_move

    task test_bits();
        prog({16'h7012, 16'h0000, 16'h0400, 16'h5017, 16'h5110, 16'h5214, 16'h1101, 16'h5315, 16'h5417,
            16'h0001});
        u_mem.mem[9'h000 + 9'h200] = 16'h0f77;
        start(1'b1);
        wait_sleep();
        chk("bit target", 32'h3e77, {16'h0, u_mem.mem[9'h200]});
        chk("byte reads", 32'h5, {24'h0, brd});
        chk("byte writes", 32'h5, {24'h0, bwr});
        chk("pc", 32'h14, {8'h0, pc});
        $display("test bits done");
    endtask : test_bits

    task test_branch();
        prog({16'h1104, 16'h3008, 16'h1000, 16'h2008, 16'h6702, 16'h0001, 16'h6202, 16'h6302, 16'h0001, 16'h0001});
        start(1'b0);
        wait_sleep();
        chk("flags", 32'h04, {24'h0, flags});
        chk("pc", 32'h14, {8'h0, pc});
        $display("test branch done");
    endtask : test_branch

    task test_trap();
        int n;
        prog({16'h1101, 16'h0012, 16'h0001});
        u_mem.mem[9'h040] = 16'h0002;
        start(1'b0);
        n = 0;
        while (trap_req !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        #1;
        chk("trap request", 32'h1, {31'h0, trap_req});
        chk("trap vector", 32'h2, {30'h0, trap_vec});
        chk("flags in trap", 32'h81, {24'h0, flags});
        @(posedge mclk);
        trap_ack <= 1'b1;
        vec_addr <= 24'h000080;
        @(posedge mclk);
        trap_ack <= 1'b0;
        wait_sleep();
        chk("pc after return", 32'h06, {8'h0, pc});
        chk("flags after return", 32'h01, {24'h0, flags});
        $display("test trap done");
    endtask : test_trap

    initial begin
        resetn = 1'b0;
        trap_ack = 1'b0;
        wake = 1'b0;
        slow = 1'b0;
        vec_addr = 24'h000000;
        repeat (2) @(posedge mclk);
        test_flags();
        test_store_load();
        test_move();
        test_bits();
        test_trap();
        test_branch();
        end_of_test();
    end
endmodule : cpu_system_control_decode_tb_top
`default_nettype wire

// ### bench/scd_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module scd_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire scd_pkg::scd_mem_req_type req_in,
    output var scd_pkg::scd_mem_rsp_type rsp_out,
    output logic [7:0] byte_rd_cnt,
    output logic [7:0] byte_wr_cnt
);
    import scd_pkg::*;
    // Plain big-endian RAM, 1 KiB decoded: no write-only bits or ports here
    logic [15:0] mem [0:511];
    logic [2:0] wait_cnt;
    logic [15:0] last;
    logic [15:0] rd;
    logic [8:0] idx;

    always @(posedge clk) begin
        if (!rst_n) begin
            rsp_out <= '0;
            wait_cnt <= 3'h0;
            last <= 16'h0000;
            byte_rd_cnt <= 8'h00;
            byte_wr_cnt <= 8'h00;
        end else begin
            rsp_out.ack <= 1'b0;
            // Idle data is scrambled so a stale read never looks valid
            rsp_out.rdata <= ~last;
            if (req_in.req && !rsp_out.ack) begin
                if (slow && wait_cnt != 3'h3) begin
                    wait_cnt <= wait_cnt + 3'h1;
                end else begin
                    wait_cnt <= 3'h0;
                    idx = req_in.addr[9:1];
                    rd = mem[idx];
                    if (req_in.byte_sz) begin
                        rd = req_in.addr[0] ? {~mem[idx][7:0], mem[idx][7:0]} : {~mem[idx][15:8], mem[idx][15:8]};
                    end
                    if (req_in.we && req_in.byte_sz) begin
                        if (req_in.addr[0]) begin
                            mem[idx][7:0] <= req_in.wdata[7:0];
                        end else begin
                            mem[idx][15:8] <= req_in.wdata[7:0];
                        end
                    end else if (req_in.we) begin
                        mem[idx] <= req_in.wdata;
                    end
                    if (req_in.byte_sz && req_in.we) begin
                        byte_wr_cnt <= byte_wr_cnt + 8'h01;
                    end
                    if (req_in.byte_sz && !req_in.we) begin
                        byte_rd_cnt <= byte_rd_cnt + 8'h01;
                    end
                    rsp_out.ack <= 1'b1;
                    rsp_out.rdata <= rd;
                    last <= rd;
                end
            end
        end
    end
endmodule : scd_mem_model
`default_nettype wire

// ### logic/scd_byte_alu.sv
`timescale 1ns/100ps
`default_nettype none
module scd_byte_alu (
    input wire logic bit_mode,
    input wire logic [2:0] sel,
    input wire logic [7:0] imm,
    input wire logic [7:0] flags,
    input wire logic [7:0] data,
    output logic [7:0] flags_out,
    output logic [7:0] data_out
);
    import scd_pkg::*;
    always_comb begin
        flags_out = flags;
        data_out = data;
        if (!bit_mode) begin
            case (sel[1:0])
                LOGIC_AND: flags_out = flags & imm;
                LOGIC_OR: flags_out = flags | imm;
                LOGIC_XOR: flags_out = flags ^ imm;
                default: flags_out = flags;
            endcase
        end else begin
            case (sel)
                BIT_SET: data_out[imm[2:0]] = 1'b1;
                BIT_CLR: data_out[imm[2:0]] = 1'b0;
                BIT_NOT: data_out[imm[2:0]] = !data[imm[2:0]];
                BIT_ST: data_out[imm[2:0]] = flags[CCR_C];
                BIT_IST: data_out[imm[2:0]] = !flags[CCR_C];
                default: data_out = data;
            endcase
        end
    end
endmodule : scd_byte_alu
`default_nettype wire

// ### logic/scd_cond.sv
`timescale 1ns/100ps
`default_nettype none
module scd_cond (
    input wire logic [3:0] cc,
    input wire logic [7:0] flags,
    output logic taken
);
    import scd_pkg::*;
    logic expr;
    // Odd codes take the branch when the test is 1, even codes when it is 0
    always_comb begin
        case (cc[3:1])
            3'h0: expr = 1'b0;
            3'h1: expr = flags[CCR_C] | flags[CCR_Z];
            3'h2: expr = flags[CCR_C];
            3'h3: expr = flags[CCR_Z];
            3'h4: expr = flags[CCR_V];
            3'h5: expr = flags[CCR_N];
            3'h6: expr = flags[CCR_N] ^ flags[CCR_V];
            default: expr = flags[CCR_Z] | (flags[CCR_N] ^ flags[CCR_V]);
        endcase
        taken = cc[0] ? expr : !expr;
    end
endmodule : scd_cond
`default_nettype wire

// ### logic/scd_core.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Trap instruction saves context and enters trap exception processing.
// - Exception return restores saved PC and flags, resuming the program.
// - Sleep instruction halts the core in low power until woken.
// - Flag load from memory reads a word, keeps only the flag byte.
// - Flag store to memory issues a word-wide write.
// - Three immediate instructions AND, OR or XOR the flag register.
// - No-operation only advances the PC by 2.
// - Block move copies bytes, bumps both pointers, counts down; zero moves nothing.
// - Count from register 4 low byte or word; pointers in registers 5, 6.
// - Next instruction starts right after the block move ends.
// - Instructions are fetched and decoded as whole 16-bit words.
// - Top four bits of the first word always hold the operation.
// - Register fields: 3-bit address register, 3 or 4-bit data register.
// - Extension words give 8, 16 or 32-bit immediate values.
// - A 24-bit extension is kept as 32 bits with top byte zero.
// - Branch words carry a condition field choosing the flag test.
// - Bit instructions read a byte, change one bit, write it back.
// - A branch is taken only when its flag condition is true.
module scd_core (
    input wire logic MCLK,
    input wire logic RESETN,
    output var scd_pkg::scd_mem_req_type MEM_OUT,
    input wire scd_pkg::scd_mem_rsp_type MEM_IN,
    output logic TRAP_REQ,
    output logic [1:0] TRAP_VEC,
    input wire logic TRAP_ACK,
    input wire logic [scd_pkg::AW-1:0] VEC_ADDR,
    input wire logic WAKE,
    output logic SLEEPING,
    output logic [7:0] FLAGS,
    output logic [scd_pkg::AW-1:0] PC
);
    import scd_pkg::*;

    scd_core_state_type r_reg, r_next;
    scd_instr_type ir;
    logic [11:0] sys_code;
    logic [7:0] imm8;
    logic [AW-1:0] disp;
    logic is_nop, is_sleep, is_rte, is_trap, ex;
    logic taken;
    logic [7:0] alu_flags, alu_byte, rd_byte, op_byte;
    logic [15:0] mv_count;
    logic [31:0] imm_val;

    assign ir = r_reg.ir;
    assign sys_code = {ir.fa, ir.fb, ir.reg_a, ir.fc};
    assign imm8 = {ir.fb, ir.reg_a, ir.fc};
    assign disp = {{(AW-8){imm8[7]}}, imm8};
    assign ex = r_reg.state == S_EXEC;
    assign is_nop = ir.op == OP_SYS && sys_code == SYS_NOP;
    assign is_sleep = ir.op == OP_SYS && sys_code == SYS_SLEEP;
    assign is_rte = ir.op == OP_SYS && sys_code == SYS_RTE;
    assign is_trap = ir.op == OP_SYS && sys_code[11:2] == SYS_TRAP_HI;
    // Bit field 4-bit form: top bit picks the low byte of the 16-bit register
    assign rd_byte = ir.fc[3] ? r_reg.gpr[ir.fc[2:0]][7:0] : r_reg.gpr[ir.fc[2:0]][15:8];
    assign op_byte = (r_reg.state == S_RD) ? MEM_IN.rdata[7:0] : rd_byte;

    assign MEM_OUT = r_reg.mem;
    assign TRAP_REQ = r_reg.trap_req;
    assign TRAP_VEC = r_reg.trap_vec;
    assign SLEEPING = r_reg.sleeping;
    assign FLAGS = r_reg.flag_register;
    assign PC = r_reg.pc;

    scd_cond u_cond (
        .cc(ir.fa),
        .flags(r_reg.flag_register),
        .taken(taken)
    );

    scd_byte_alu u_alu (
        .bit_mode(ir.op == OP_BIT),
        .sel(ir.fa[2:0]),
        .imm(imm8),
        .flags(r_reg.flag_register),
        .data(op_byte),
        .flags_out(alu_flags),
        .data_out(alu_byte)
    );

    function automatic scd_mem_req_type mreq(input logic we, input logic bsz,
                                             input logic [AW-1:0] a, input logic [15:0] d);
        mreq.req = 1'b1;
        mreq.we = we;
        mreq.byte_sz = bsz;
        mreq.addr = a;
        mreq.wdata = d;
    endfunction : mreq

    always_comb begin
        r_next = r_reg;
        mv_count = ir.fc[0] ? r_reg.gpr[COUNT_REG][15:0] : {8'h00, r_reg.gpr[COUNT_REG][7:0]};
        case (ir.fc[1:0])
            EXT_8: imm_val = {24'h000000, r_reg.ext[7:0]};
            EXT_16: imm_val = {16'h0000, r_reg.ext[15:0]};
            EXT_32: imm_val = r_reg.ext;
            default: imm_val = {8'h00, r_reg.ext[23:0]};
        endcase
        if (MEM_IN.ack) begin
            r_next.mem.req = 1'b0;
        end
        case (r_reg.state)
            S_FETCH: begin
                if (!r_reg.mem.req) begin
                    r_next.mem = mreq(1'b0, 1'b0, r_reg.pc, 16'h0000);
                end else if (MEM_IN.ack) begin
                    r_next.ir = MEM_IN.rdata;
                    r_next.pc = r_reg.pc + PC_STEP;
                    r_next.state = S_DECODE;
                end
            end
            S_DECODE: begin
                // Only the immediate-load group carries extension words
                if (ir.op == OP_IMM) begin
                    r_next.ext_cnt = ir.fc[1] ? TWO_WORDS : ONE_WORD;
                    r_next.state = S_EXT;
                end else begin
                    r_next.state = S_EXEC;
                end
            end
            S_EXT: begin
                if (!r_reg.mem.req) begin
                    r_next.mem = mreq(1'b0, 1'b0, r_reg.pc, 16'h0000);
                end else if (MEM_IN.ack) begin
                    r_next.ext = {r_reg.ext[15:0], MEM_IN.rdata};
                    r_next.pc = r_reg.pc + PC_STEP;
                    r_next.ext_cnt = r_reg.ext_cnt - ONE_WORD;
                    if (r_reg.ext_cnt == ONE_WORD) begin
                        r_next.state = S_EXEC;
                    end
                end
            end
            S_EXEC: begin
                r_next.state = S_FETCH;
                case (ir.op)
                    OP_SYS: begin
                        if (is_trap) begin
                            r_next.saved_pc = r_reg.pc;
                            r_next.saved_ccr = r_reg.flag_register;
                            r_next.flag_register[CCR_I] = 1'b1;
                            r_next.trap_req = 1'b1;
                            r_next.trap_vec = ir.fc[1:0];
                            r_next.state = S_TRAP;
                        end else if (is_rte) begin
                            r_next.pc = r_reg.saved_pc;
                            r_next.flag_register = r_reg.saved_ccr;
                        end else if (is_sleep) begin
                            r_next.sleeping = 1'b1;
                            r_next.state = S_SLEEP;
                        end
                        // Nothing changes for the no-operation word
                    end
                    OP_FLAG_LOGIC: begin
                        r_next.flag_register = alu_flags;
                    end
                    OP_FLAG_LOAD: begin
                        if (ir.fa[3]) begin
                            // Word read from the even address holding the flag byte
                            r_next.mem = mreq(1'b0, 1'b0, {r_reg.gpr[ir.reg_a][AW-1:1], 1'b0},
                                              16'h0000);
                            r_next.state = S_RD;
                        end else begin
                            r_next.flag_register = rd_byte;
                        end
                    end
                    OP_FLAG_STORE: begin
                        if (ir.fa[3]) begin
                            r_next.mem = mreq(1'b1, 1'b0, {r_reg.gpr[ir.reg_a][AW-1:1], 1'b0},
                                              {r_reg.flag_register, 8'h00});
                            r_next.state = S_WR;
                        end else if (ir.fc[3]) begin
                            r_next.gpr[ir.fc[2:0]][7:0] = r_reg.flag_register;
                        end else begin
                            r_next.gpr[ir.fc[2:0]][15:8] = r_reg.flag_register;
                        end
                    end
                    OP_MOVE: begin
                        r_next.state = S_MV_CHK;
                    end
                    OP_BIT: begin
                        r_next.mem = mreq(1'b0, 1'b1, r_reg.gpr[ir.reg_a][AW-1:0], 16'h0000);
                        r_next.state = S_RD;
                    end
                    OP_BRANCH: begin
                        if (taken) begin
                            r_next.pc = r_reg.pc + disp;
                        end
                    end
                    OP_IMM: begin
                        r_next.gpr[ir.reg_a] = imm_val;
                    end
                    default: begin
                        r_next.state = S_FETCH;
                    end
                endcase
            end
            S_RD: begin
                if (MEM_IN.ack) begin
                    if (ir.op == OP_FLAG_LOAD) begin
                        r_next.flag_register = MEM_IN.rdata[15:8];
                        r_next.state = S_FETCH;
                    end else begin
                        // Whole byte goes back, so write-only bits read as junk are rewritten
                        r_next.mem = mreq(1'b1, 1'b1, r_reg.mem.addr, {8'h00, alu_byte});
                        r_next.state = S_WR;
                    end
                end
            end
            S_WR: begin
                if (MEM_IN.ack) begin
                    r_next.state = S_FETCH;
                end
            end
            S_MV_CHK: begin
                if (mv_count == 16'h0000) begin
                    r_next.state = S_FETCH;
                end else begin
                    r_next.mem = mreq(1'b0, 1'b1, r_reg.gpr[SRC_REG][AW-1:0], 16'h0000);
                    r_next.state = S_MV_RD;
                end
            end
            S_MV_RD: begin
                if (MEM_IN.ack) begin
                    r_next.gpr[SRC_REG] = r_reg.gpr[SRC_REG] + PTR_STEP;
                    r_next.mem = mreq(1'b1, 1'b1, r_reg.gpr[DST_REG][AW-1:0],
                                      {8'h00, MEM_IN.rdata[7:0]});
                    r_next.state = S_MV_WR;
                end
            end
            S_MV_WR: begin
                if (MEM_IN.ack) begin
                    r_next.gpr[DST_REG] = r_reg.gpr[DST_REG] + PTR_STEP;
                    if (ir.fc[0]) begin
                        r_next.gpr[COUNT_REG][15:0] = mv_count - 16'h0001;
                    end else begin
                        r_next.gpr[COUNT_REG][7:0] = mv_count[7:0] - 8'h01;
                    end
                    r_next.state = S_MV_CHK;
                end
            end
            S_TRAP: begin
                // Vector fetch lives outside; it hands back the handler address
                if (TRAP_ACK) begin
                    r_next.trap_req = 1'b0;
                    r_next.pc = {VEC_ADDR[AW-1:1], 1'b0};
                    r_next.state = S_FETCH;
                end
            end
            S_SLEEP: begin
                if (WAKE) begin
                    r_next.sleeping = 1'b0;
                    r_next.state = S_FETCH;
                end
            end
            default: begin
                r_next.state = S_FETCH;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);

    a_trap_entry: assert property (ex && is_trap |=> TRAP_REQ && FLAGS[CCR_I] ##1 !MEM_OUT.req)
        else $error("trap did not enter exception processing");
    a_rte_resume: assert property (ex && is_rte |=> PC == $past(r_reg.saved_pc) && FLAGS == $past(r_reg.saved_ccr))
        else $error("return did not restore context");
    a_sleep_halt: assert property (ex && is_sleep |=> SLEEPING && !MEM_OUT.req)
        else $error("sleep did not halt");
    a_flag_load_word: assert property (r_reg.state == S_RD && ir.op == OP_FLAG_LOAD && MEM_IN.ack
        |-> !MEM_OUT.byte_sz ##1 FLAGS == $past(MEM_IN.rdata[15:8]))
        else $error("flag load not a word read");
    a_flag_store_word: assert property (r_reg.state == S_WR && ir.op == OP_FLAG_STORE
        |-> MEM_OUT.req && MEM_OUT.we && !MEM_OUT.byte_sz && MEM_OUT.wdata[15:8] == FLAGS)
        else $error("flag store not a word write");
    a_flag_xor: assert property (ex && ir.op == OP_FLAG_LOGIC && ir.fa[1:0] == LOGIC_XOR
        |=> FLAGS == ($past(FLAGS) ^ $past(imm8)))
        else $error("flag xor wrong");
    a_nop_step: assert property (r_reg.state == S_DECODE && is_nop
        |-> PC == $past(PC) + PC_STEP ##2 PC == $past(PC, 2) && FLAGS == $past(FLAGS, 2))
        else $error("no-operation changed state");
    a_move_zero: assert property (r_reg.state == S_MV_CHK && mv_count == 16'h0000
        |=> r_reg.state == S_FETCH ##1 MEM_OUT.req && MEM_OUT.addr == PC)
        else $error("empty move did not resume");
    a_move_ptrs: assert property (r_reg.state == S_MV_RD && MEM_IN.ack
        |-> MEM_OUT.addr == r_reg.gpr[SRC_REG][AW-1:0]
        ##1 MEM_OUT.we && MEM_OUT.addr == r_reg.gpr[DST_REG][AW-1:0])
        else $error("move pointers wrong");
    a_ext_top_zero: assert property (ex && ir.op == OP_IMM && ir.fc[1:0] == EXT_24
        |=> r_reg.gpr[$past(ir.reg_a)] == {8'h00, $past(r_reg.ext[23:0])})
        else $error("24-bit extension top byte not zero");
    a_bit_rmw: assert property (r_reg.state == S_RD && ir.op == OP_BIT && MEM_IN.ack
        |-> MEM_OUT.byte_sz ##1 MEM_OUT.we && MEM_OUT.byte_sz && MEM_OUT.addr == $past(MEM_OUT.addr))
        else $error("bit op not written back in place");
    a_branch_cond: assert property (ex && ir.op == OP_BRANCH
        |=> PC == ($past(taken) ? $past(PC) + $past(disp) : $past(PC)))
        else $error("branch target wrong");
    a_word_fetch: assert property (r_reg.state == S_FETCH && MEM_OUT.req |-> !MEM_OUT.byte_sz && !MEM_OUT.we)
        else $error("fetch not a word read");
    a_op_field: assert property (r_reg.state == S_DECODE |-> ir.op == $past(MEM_IN.rdata[15:12]))
        else $error("operation field lost");
    a_flag_and: assert property (ex && ir.op == OP_FLAG_LOGIC && ir.fa[1:0] == LOGIC_AND
        |=> FLAGS == ($past(FLAGS) & $past(imm8)))
        else $error("flag and wrong");
    a_flag_or: assert property (ex && ir.op == OP_FLAG_LOGIC && ir.fa[1:0] == LOGIC_OR
        |=> FLAGS == ($past(FLAGS) | $past(imm8)))
        else $error("flag or wrong");
    a_ext_16: assert property (ex && ir.op == OP_IMM && ir.fc[1:0] == EXT_16
        |=> r_reg.gpr[$past(ir.reg_a)] == {16'h0000, $past(r_reg.ext[15:0])})
        else $error("16-bit extension wrong");
    a_cond_higher: assert property (ex && ir.op == OP_BRANCH && ir.fa == 4'h2
        |=> PC == ($past(FLAGS[CCR_C] | FLAGS[CCR_Z]) ? $past(PC) : $past(PC) + $past(disp)))
        else $error("higher-than branch wrong");
    a_move_count: assert property (r_reg.state == S_MV_WR && MEM_IN.ack
        |=> mv_count == $past(mv_count) - 16'h0001)
        else $error("move count not decremented");
    a_trap_vector: assert property (r_reg.state == S_TRAP && TRAP_ACK
        |=> !TRAP_REQ && PC == {$past(VEC_ADDR[AW-1:1]), 1'b0})
        else $error("trap handler address wrong");
    a_sleep_hold: assert property (SLEEPING && !WAKE
        |=> SLEEPING && !MEM_OUT.req && PC == $past(PC))
        else $error("left sleep without wake");
    a_trap_hold: assert property (TRAP_REQ && !TRAP_ACK |=> TRAP_REQ)
        else $error("trap request dropped");
endmodule : scd_core
`default_nettype wire

// ### logic/scd_pkg.sv
`default_nettype none
package scd_pkg;
    localparam int AW = 24;
    // Major operation in the top nibble of the first word
    localparam logic [3:0] OP_SYS = 4'h0;
    localparam logic [3:0] OP_FLAG_LOGIC = 4'h1;
    localparam logic [3:0] OP_FLAG_LOAD = 4'h2;
    localparam logic [3:0] OP_FLAG_STORE = 4'h3;
    localparam logic [3:0] OP_MOVE = 4'h4;
    localparam logic [3:0] OP_BIT = 4'h5;
    localparam logic [3:0] OP_BRANCH = 4'h6;
    localparam logic [3:0] OP_IMM = 4'h7;
    localparam logic [11:0] SYS_NOP = 12'h000;
    localparam logic [11:0] SYS_SLEEP = 12'h001;
    localparam logic [11:0] SYS_RTE = 12'h002;
    localparam logic [9:0] SYS_TRAP_HI = 10'h004;
    localparam logic [1:0] LOGIC_AND = 2'h0;
    localparam logic [1:0] LOGIC_OR = 2'h1;
    localparam logic [1:0] LOGIC_XOR = 2'h2;
    localparam logic [2:0] BIT_SET = 3'h0;
    localparam logic [2:0] BIT_CLR = 3'h1;
    localparam logic [2:0] BIT_NOT = 3'h2;
    localparam logic [2:0] BIT_ST = 3'h3;
    localparam logic [2:0] BIT_IST = 3'h4;
    localparam logic [1:0] EXT_8 = 2'h0;
    localparam logic [1:0] EXT_16 = 2'h1;
    localparam logic [1:0] EXT_32 = 2'h2;
    localparam logic [1:0] EXT_24 = 2'h3;
    localparam int CCR_I = 7;
    localparam int CCR_N = 3;
    localparam int CCR_Z = 2;
    localparam int CCR_V = 1;
    localparam int CCR_C = 0;
    localparam logic [2:0] COUNT_REG = 3'h4;
    localparam logic [2:0] SRC_REG = 3'h5;
    localparam logic [2:0] DST_REG = 3'h6;
    localparam logic [AW-1:0] PC_STEP = 24'h000002;
    localparam logic [31:0] PTR_STEP = 32'h00000001;
    localparam logic [1:0] ONE_WORD = 2'h1;
    localparam logic [1:0] TWO_WORDS = 2'h2;

    typedef enum logic [3:0] {
        S_FETCH = 4'h0, S_DECODE = 4'h1, S_EXT = 4'h3, S_EXEC = 4'h2,
        S_RD = 4'h6, S_WR = 4'h7, S_MV_CHK = 4'h5, S_MV_RD = 4'h4,
        S_MV_WR = 4'hc, S_TRAP = 4'hd, S_SLEEP = 4'hf
    } scd_state_type;

    typedef struct packed {
        logic [3:0] op;
        logic [3:0] fa;
        logic fb;
        logic [2:0] reg_a;
        logic [3:0] fc;
    } scd_instr_type;

    typedef struct packed {
        logic req;
        logic we;
        logic byte_sz;
        logic [AW-1:0] addr;
        logic [15:0] wdata;
    } scd_mem_req_type;

    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
    } scd_mem_rsp_type;

    typedef struct packed {
        scd_state_type state;
        logic [AW-1:0] pc;
        logic [7:0] flag_register;
        logic [7:0][31:0] gpr;
        logic [AW-1:0] saved_pc;
        logic [7:0] saved_ccr;
        scd_instr_type ir;
        logic [31:0] ext;
        logic [1:0] ext_cnt;
        scd_mem_req_type mem;
        logic trap_req;
        logic [1:0] trap_vec;
        logic sleeping;
    } scd_core_state_type;
endpackage : scd_pkg
`default_nettype wire
